/* File: common/ee_pkg.sv */
// Shared constants and types for the serial EEPROM status and framing core.
// Assumes a single 125 MHz system clock samples every serial pin.
package ee_pkg;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;  // set_write_latch_cmd
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;  // clear_write_latch_cmd
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_WRITE     = 8'h02;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;  // status_read_cmd
  localparam logic [7:0] OP_STAT_WR   = 8'h01;  // status_write_cmd

  // ----------------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------------
  localparam int PIN_EN_BIT = 7;                // protect_pin_enable
  localparam int BP_HI_BIT  = 3;                // block_protect_high
  localparam int BP_LO_BIT  = 2;                // block_protect_low
  localparam int LATCH_BIT  = 1;
  localparam int BUSY_BIT   = 0;
  localparam logic [2:0] NV_RESET    = 3'h0;    // {pin enable, bp high, low}
  localparam logic       LATCH_RESET = 1'h0;

  // ----------------------------------------------------------------------
  // Array protection and geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] PROT_QTR_BASE  = 10'h300;
  localparam logic [9:0] PROT_HALF_BASE = 10'h200;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int WRITE_TIME_MS = 5;             // internal_write_cycle_time
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic hold_n;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
  } pins_t;

  localparam logic [4:0] PINS_IDLE = 5'h1C;     // Hold, protect, select high

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } arr_word_t;

  typedef enum logic [4:0] {
    F_IDLE = 5'b00001,
    F_ADDR = 5'b00010,
    F_DATA = 5'b00100,
    F_STAT = 5'b01000,
    F_SKIP = 5'b10000
  } frame_t;

endpackage : ee_pkg

/* File: core/pin_sync.sv */
// Two-flop synchronisers, one per bit, for the serial pins.
// Assumes the pins are asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int           W   = 5,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         CLK,
  input  wire logic         RESET_N,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  // ----------------------------------------------------------------------
  // Per-bit chain; the first stage feeds only the second
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        meta_q <= RST[i];
        q[i]   <= RST[i];
      end else begin
        meta_q <= d[i];
        q[i]   <= meta_q;
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

/* File: core/word_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes push and pop come from logic on CLK.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 8
) (
  input  wire logic         CLK,
  input  wire logic         RESET_N,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // ----------------------------------------------------------------------
  // Pointer and count update
  // ----------------------------------------------------------------------
  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem[rd_q];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wr_d      = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d      = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge CLK) begin
    if (push && !flush) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule : word_fifo
`default_nettype wire

/* File: core/ee_status_core.sv */
// Serial framing, command handling and status register of the EEPROM.
// Assumes the serial pins come straight from the host; the array itself
// and its storage of the protect bits sit outside, on CLK.
`timescale 1ns/1ps
`default_nettype none
module ee_status_core #(
  parameter int WRITE_CYCLES = ee_pkg::WRITE_CYCLES
) (
  input  wire logic                     CLK,
  input  wire logic                     RESET_N,
  input  wire logic                     SCK,
  input  wire logic                     CS_N,
  input  wire logic                     SI,
  input  wire logic                     HOLD_N,
  input  wire logic                     WP_N,
  output var  logic                     SO,
  output var  logic                     SO_OE,
  input  wire logic [2:0]               NV_BITS_IN,
  output var  logic [2:0]               NV_BITS_OUT,
  output var  logic                     NV_SAVE,
  output var  logic                     BUSY,
  output var  logic                     ARR_VALID,
  input  wire logic                     ARR_READY,
  output var  logic [ee_pkg::ADDR_W-1:0] ARR_ADDR,
  output var  logic [7:0]               ARR_DATA
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  ee_pkg::pins_t      pins_raw, p;
  ee_pkg::frame_t     st_q, st_d;
  ee_pkg::arr_word_t  push_word, pop_word;
  logic [2:0]  bitcnt_q, bitcnt_d;
  logic [6:0]  shin_q, shin_d, shout_q, shout_d;
  logic [9:0]  addr_q, addr_d, push_addr;
  logic [3:0]  idx_q, idx_d;
  logic [7:0]  stat_byte_q, stat_byte_d, byte_w, status_w;
  logic [2:0]  nv_q, nv_d;
  logic [TW-1:0] timer_q, timer_d;
  logic sck_q, cs_q, op_mem_q, op_mem_d, got_q, got_d, cancel_q, cancel_d;
  logic wen_q, wen_d, loaded_q, loaded_d, busy_q, busy_d, drain_q, drain_d;
  logic save_q, save_d, so_q, so_d;
  logic rise, fall, cs_rise, byte_done, prot, push, commit, flush;
  logic f_in_ready, f_out_valid;

  // ----------------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------------
  assign pins_raw = '{hold_n: HOLD_N, wp_n: WP_N, cs_n: CS_N,
                      sck: SCK, si: SI};

  pin_sync #(.W(5), .RST(ee_pkg::PINS_IDLE)) u_sync (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .d       (pins_raw),
    .q       (p)
  );

  // ----------------------------------------------------------------------
  // Edge detection and decode terms
  // ----------------------------------------------------------------------
  // Edges are found on the sampled clock, so idle level does not matter
  assign rise = p.sck & ~sck_q & ~p.cs_n & p.hold_n;
  assign fall = ~p.sck & sck_q & ~p.cs_n & p.hold_n;
  assign cs_rise   = p.cs_n & ~cs_q;
  assign byte_done = rise & (bitcnt_q == 3'h7);
  assign byte_w    = {shin_q, p.si};
  assign status_w  = {nv_q[2], 3'h0, nv_q[1:0], wen_q, busy_q};
  // Page address wraps in its low nibble
  assign push_addr = {addr_q[9:4], 4'(addr_q[3:0] + idx_q)};

  // Protected region decode
  always_comb begin
    case (nv_q[1:0])
      2'h0:    prot = 1'b0;
      2'h1:    prot = (push_addr >= ee_pkg::PROT_QTR_BASE);
      2'h2:    prot = (push_addr >= ee_pkg::PROT_HALF_BASE);
      default: prot = 1'b1;
    endcase
  end

  assign push = byte_done & (st_q == ee_pkg::F_DATA) & op_mem_q &
                ~prot & ~cancel_q;
  // Commit only on select rising at a byte boundary with data taken
  assign commit = cs_rise & (st_q == ee_pkg::F_DATA) &
                  (bitcnt_q == 3'h0) & got_q & ~cancel_q & wen_q &
                  ~busy_q &
                  (op_mem_q | ~(nv_q[2] & ~p.wp_n));
  // Uncommitted page data is thrown away with the frame
  assign flush = cs_rise & ~commit & ~drain_q;

  // ----------------------------------------------------------------------
  // Frame, command and status state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;  bitcnt_d = bitcnt_q;  shin_d = shin_q;
    addr_d = addr_q;  idx_d = idx_q;  stat_byte_d = stat_byte_q;
    op_mem_d = op_mem_q;  got_d = got_q;  cancel_d = cancel_q;
    wen_d = wen_q;  nv_d = nv_q;  loaded_d = 1'b1;  save_d = 1'b0;
    busy_d = busy_q;  drain_d = drain_q;  timer_d = timer_q;
    if (!loaded_q) begin
      nv_d = NV_BITS_IN;                          // Restore stored bits
    end
    if (p.cs_n) begin
      st_d     = ee_pkg::F_IDLE;
      bitcnt_d = 3'h0;
    end else if (rise) begin
      bitcnt_d = 3'(bitcnt_q + 3'h1);
      shin_d   = byte_w[6:0];
      if (bitcnt_q == 3'h7) begin
        case (st_q)
          ee_pkg::F_IDLE: begin
            got_d    = 1'b0;
            cancel_d = 1'b0;
            idx_d    = 4'h0;
            if (busy_q && byte_w != ee_pkg::OP_STAT_RD) begin
              st_d = ee_pkg::F_SKIP;
            end else begin
              case (byte_w)
                ee_pkg::OP_SET_LATCH: begin
                  wen_d = 1'b1;
                  st_d  = ee_pkg::F_SKIP;
                end
                ee_pkg::OP_CLR_LATCH: begin
                  wen_d = 1'b0;
                  st_d  = ee_pkg::F_SKIP;
                end
                ee_pkg::OP_STAT_RD: st_d = ee_pkg::F_STAT;
                ee_pkg::OP_STAT_WR: begin
                  op_mem_d = 1'b0;
                  st_d     = ee_pkg::F_DATA;
                end
                ee_pkg::OP_WRITE: begin
                  op_mem_d = 1'b1;
                  st_d     = ee_pkg::F_ADDR;
                end
                default: st_d = ee_pkg::F_SKIP;   // Array read lives outside
              endcase
            end
          end
          ee_pkg::F_ADDR: begin
            if (!got_q) begin
              addr_d[9:8] = byte_w[1:0];
              got_d       = 1'b1;
            end else begin
              addr_d[7:0] = byte_w;
              got_d       = 1'b0;
              st_d        = ee_pkg::F_DATA;
            end
          end
          ee_pkg::F_DATA: begin
            got_d       = 1'b1;
            stat_byte_d = byte_w;
            if (op_mem_q) begin
              idx_d = 4'(idx_q + 4'h1);
            end
          end
          default: ;
        endcase
      end
    end
    // A page longer than the buffer cancels the write
    if (push && !f_in_ready) begin
      cancel_d = 1'b1;
    end
    if (commit) begin
      wen_d   = 1'b0;
      busy_d  = 1'b1;
      drain_d = 1'b1;
      timer_d = TW'(WRITE_CYCLES - 1);
      if (!op_mem_q) begin
        nv_d   = {stat_byte_q[ee_pkg::PIN_EN_BIT],
                  stat_byte_q[ee_pkg::BP_HI_BIT:ee_pkg::BP_LO_BIT]};
        save_d = 1'b1;
      end
    end else if (busy_q) begin
      if (timer_q != '0) begin
        timer_d = TW'(timer_q - 1'b1);
      end else if (!f_out_valid) begin
        busy_d  = 1'b0;
        drain_d = 1'b0;
      end
    end
  end

  // Latch resets clear, as after a power cycle; protect bits reload
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= ee_pkg::F_IDLE;  bitcnt_q <= 3'h0;  shin_q <= 7'h00;
      addr_q <= 10'h000;  idx_q <= 4'h0;  stat_byte_q <= 8'h00;
      op_mem_q <= 1'b0;  got_q <= 1'b0;  cancel_q <= 1'b0;
      wen_q <= ee_pkg::LATCH_RESET;
      nv_q <= ee_pkg::NV_RESET;  loaded_q <= 1'b0;  save_q <= 1'b0;
      busy_q <= 1'b0;  drain_q <= 1'b0;  timer_q <= '0;
      sck_q <= 1'b0;  cs_q <= 1'b1;
    end else begin
      st_q <= st_d;  bitcnt_q <= bitcnt_d;  shin_q <= shin_d;
      addr_q <= addr_d;  idx_q <= idx_d;  stat_byte_q <= stat_byte_d;
      op_mem_q <= op_mem_d;  got_q <= got_d;  cancel_q <= cancel_d;
      wen_q <= wen_d;  nv_q <= nv_d;  loaded_q <= loaded_d;
      save_q <= save_d;  busy_q <= busy_d;  drain_q <= drain_d;
      timer_q <= timer_d;  sck_q <= p.sck;  cs_q <= p.cs_n;
    end
  end

  // ----------------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------------
  // Status repeats every eight clocks for as long as select stays low
  always_comb begin
    so_d    = so_q;
    shout_d = shout_q;
    if (fall && st_q == ee_pkg::F_STAT) begin
      if (bitcnt_q == 3'h0) begin
        {so_d, shout_d} = status_w;
      end else begin
        {so_d, shout_d} = {shout_q, 1'b0};
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      so_q    <= 1'b0;
      shout_q <= 7'h00;
    end else begin
      so_q    <= so_d;
      shout_q <= shout_d;
    end
  end

  assign SO          = so_q;
  assign SO_OE       = ~p.cs_n & p.hold_n & (st_q == ee_pkg::F_STAT);
  assign NV_BITS_OUT = nv_q;
  assign NV_SAVE     = save_q;
  assign BUSY        = busy_q;

  // ----------------------------------------------------------------------
  // Page buffer toward the array; drained only once the write commits
  // ----------------------------------------------------------------------
  assign push_word = '{addr: push_addr, data: byte_w};

  word_fifo #(.W(18), .DEPTH(ee_pkg::FIFO_DEPTH)) u_fifo (
    .CLK       (CLK),
    .RESET_N   (RESET_N),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (push_word),
    .out_valid (f_out_valid),
    .out_ready (ARR_READY & drain_q),
    .out_data  (pop_word)
  );

  assign ARR_VALID = f_out_valid & drain_q;
  assign ARR_ADDR  = pop_word.addr;
  assign ARR_DATA  = pop_word.data;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence stat_load_s;
    fall && st_q == ee_pkg::F_STAT && bitcnt_q == 3'h0;
  endsequence

  sequence busy_opcode_s;
    byte_done && st_q == ee_pkg::F_IDLE && busy_q;
  endsequence

  status_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    stat_load_s |=> so_q == $past(nv_q[2]) && shout_q[6:4] == 3'h0 &&
    shout_q[0] == $past(busy_q))
    else $error("status byte not loaded onto serial output");
  so_edge_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $changed(so_q) |-> $past(fall))
    else $error("serial output moved off a falling edge");
  latch_set_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    byte_done && st_q == ee_pkg::F_IDLE && !busy_q &&
    byte_w == ee_pkg::OP_SET_LATCH |=> wen_q)
    else $error("latch not set by its command");
  latch_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    commit |=> !wen_q ##1 busy_q)
    else $error("latch still set after an executed write");
  need_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    cs_rise && !wen_q && !busy_q |=> !busy_q && $stable(nv_q))
    else $error("write executed without the latch");
  pin_refuse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    cs_rise && !op_mem_q && nv_q[2] && !p.wp_n |=> $stable(nv_q))
    else $error("status write not refused by protect pin");
  busy_filter_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    busy_opcode_s ##0 (byte_w != ee_pkg::OP_STAT_RD) |=>
    st_q == ee_pkg::F_SKIP)
    else $error("command accepted during write cycle");
  timer_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    commit |=> busy_q && timer_q == TW'(WRITE_CYCLES - 1))
    else $error("write timer not loaded");
  hold_freeze_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !p.hold_n && !p.cs_n |=> $stable(bitcnt_q) && $stable(shin_q))
    else $error("transfer advanced during hold");
  protect_push_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    push |-> nv_q[1:0] == 2'h0 ||
    (nv_q[1:0] == 2'h1 && push_addr[9:8] != 2'h3) ||
    (nv_q[1:0] == 2'h2 && !push_addr[9]))
    else $error("byte queued into a protected region");

endmodule : ee_status_core
`default_nettype wire

/* File: testbench/spi_host.sv */
// Host-side serial controller model: select, clock, data in and hold.
// Assumes the bench calls its tasks; the clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  output var  logic SCK,
  output var  logic CS_N,
  output var  logic SI,
  output var  logic HOLD_N,
  input  wire logic SO,
  input  wire logic SO_OE
);
  logic cpol    = 1'b0;  // Idle level of the clock, mode 0 or 3
  int   hold_at = -1;    // Bit index at which to pause, none if negative

  // --------------------------------------------------------------------
  // Pin defaults
  // --------------------------------------------------------------------
  initial begin
    SCK    = 1'b0;
    CS_N   = 1'b1;
    SI     = 1'b0;
    HOLD_N = 1'b1;
  end

  // Frame edges; data line flips when released so a stale bit never helps
  task sel(input logic on);
    if (on) begin
      SCK = cpol;
      #100 CS_N = 1'b0;
      #100;
    end else begin
      SCK = cpol;
      #100 CS_N = 1'b1;
      SI = ~SI;
      #300;
    end
  endtask : sel

  // One byte, MSB first, data set on the low phase, taken on the rise
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SCK = 1'b0;
      SI  = tx[i];
      if (i == hold_at) begin
        HOLD_N = 1'b0;
        repeat (2) begin
          #62.5 SCK = 1'b1;
          SI = ~SI;
          #62.5 SCK = 1'b0;
        end
        SI = tx[i];
        #62.5 HOLD_N = 1'b1;
      end
      #62.5 SCK = 1'b1;
      rx[i] = (SO_OE === 1'b1) ? SO : 1'bx;
      #62.5;
    end
  endtask : xfer
endmodule : spi_host
`default_nettype wire

/* File: testbench/spi_eeprom_status_and_framing_tb.sv */
// Self-checking bench for the status and framing core.
// Assumes the host model drives the serial pins; the bench plays the array.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_status_and_framing_tb;
  typedef struct packed {
    logic       pre;
    logic [7:0] op;
    logic [7:0] dat;
    logic       wp;
    logic [7:0] exp;
  } row_t;
  logic        clk, reset_n, sck, cs_n, si, hold_n, wp_n, so, so_oe;
  logic        nv_save, busy, arr_valid, arr_ready;
  logic [2:0]  nv_in, nv_out;
  logic [9:0]  arr_addr;
  logic [7:0]  arr_data, s;
  logic [17:0] got[$];
  int          mismatches, n_compared, cycles, saves, i;
  row_t rows[8] = '{
    '{1'b0, 8'h06, 8'h00, 1'b1, 8'h02},
    '{1'b0, 8'h04, 8'h00, 1'b1, 8'h00},
    '{1'b0, 8'h01, 8'hFF, 1'b1, 8'h00},
    '{1'b1, 8'h01, 8'h8C, 1'b1, 8'h8C},
    '{1'b1, 8'h01, 8'h00, 1'b0, 8'h8E},
    '{1'b0, 8'h03, 8'h00, 1'b1, 8'h8E},
    '{1'b1, 8'h01, 8'h07, 1'b1, 8'h04},
    '{1'b1, 8'h01, 8'h00, 1'b0, 8'h00}};

  // Write cycle long enough that a status read and a command fit inside it
  ee_status_core #(.WRITE_CYCLES(2000)) ee_status_core_inst (
    .CLK(clk), .RESET_N(reset_n), .SCK(sck), .CS_N(cs_n), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe),
    .NV_BITS_IN(nv_in), .NV_BITS_OUT(nv_out), .NV_SAVE(nv_save),
    .BUSY(busy), .ARR_VALID(arr_valid), .ARR_READY(arr_ready),
    .ARR_ADDR(arr_addr), .ARR_DATA(arr_data));
  spi_host spi_host_inst (.SCK(sck), .CS_N(cs_n), .SI(si),
    .HOLD_N(hold_n), .SO(so), .SO_OE(so_oe));

  // --------------------------------------------------------------------
  // Clock, array sink and hang guard
  // --------------------------------------------------------------------
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Ceiling is about twice the expected run, so a slow design still ends
  always @(posedge clk) begin
    cycles++;
    if (nv_save === 1'b1) saves++;
    if (arr_valid === 1'b1 && arr_ready === 1'b1) got.push_back({arr_addr, arr_data});
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task check(input string what, input logic [17:0] e, input logic [17:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Whole frame of one or two bytes; last byte seen lands in s
  task frame(input logic [7:0] a, input logic [7:0] b, input int n);
    spi_host_inst.sel(1'b1);
    spi_host_inst.xfer(a, s);
    if (n > 1) spi_host_inst.xfer(b, s);
    spi_host_inst.sel(1'b0);
    repeat (8) @(posedge clk);
  endtask : frame

  task wait_idle();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
    check("busy", 18'h0, {17'h0, busy});
  endtask : wait_idle

  // Write page of n bytes at start address
  task page(input logic [9:0] a, input int n);
    frame(8'h06, 8'h00, 1);
    spi_host_inst.sel(1'b1);
    spi_host_inst.xfer(8'h02, s);
    spi_host_inst.xfer({6'h0, a[9:8]}, s);
    spi_host_inst.xfer(a[7:0], s);
    for (int k = 0; k < n; k++) spi_host_inst.xfer(8'(8'hA0 + k), s);
    spi_host_inst.sel(1'b0);
  endtask : page

  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    arr_ready = 1'b1;
    nv_in = 3'h0;
    repeat (16) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (4) @(posedge clk);
    // Table rows: optional latch set, command, then status read back
    for (i = 0; i < 8; i++) begin
      @(negedge clk) wp_n = rows[i].wp;
      if (rows[i].pre) frame(8'h06, 8'h00, 1);
      frame(rows[i].op, rows[i].dat, (rows[i].op == 8'h01) ? 2 : 1);
      wait_idle();
      frame(8'h05, 8'h00, 2);
      check("status", {10'h0, rows[i].exp}, {10'h0, s});
      check("stored", {15'h0, rows[i].exp[7], rows[i].exp[3:2]}, {15'h0, nv_out});
      $display("row %0d done", i);
    end
    // Only status read is taken during the internal write
    frame(8'h06, 8'h00, 1);
    frame(8'h01, 8'h04, 2);
    frame(8'h05, 8'h00, 2);
    check("busy status", 18'h05, {10'h0, s});
    frame(8'h06, 8'h00, 1);
    wait_idle();
    frame(8'h05, 8'h00, 2);
    check("after busy", 18'h04, {10'h0, s});
    check("save pulses", 18'd4, 18'(saves));
    $display("busy test done");
    // Full page with the array stalled, then a page into the protected top
    @(negedge clk) arr_ready = 1'b0;
    page(10'h2F8, 8);
    repeat (300) @(posedge clk);
    check("busy stalled", 18'h1, {17'h0, busy});
    @(negedge clk) arr_ready = 1'b1;
    wait_idle();
    for (i = 0; i < 8; i++) check("word", {10'(10'h2F8 + i), 8'(8'hA0 + i)}, got[i]);
    page(10'h300, 1);
    wait_idle();
    check("word count", 18'd8, 18'(got.size()));
    $display("page test done");
    // Pause mid-byte, then a status read with the clock idling high
    spi_host_inst.hold_at = 4;
    frame(8'h06, 8'h00, 1);
    spi_host_inst.hold_at = -1;
    spi_host_inst.cpol = 1'b1;
    frame(8'h05, 8'h00, 2);
    check("held", 18'h06, {10'h0, s});
    spi_host_inst.cpol = 1'b0;
    $display("hold test done");
    // Second reset: stored bits reload, latch comes back cleared
    @(negedge clk) nv_in = 3'h6;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (4) @(posedge clk);
    check("reload", 18'h6, {15'h0, nv_out});
    frame(8'h05, 8'h00, 2);
    check("after reset", 18'h88, {10'h0, s});
    $display("reset test done");
    // Half protection drops the top byte, keeps the bottom one
    page(10'h2F0, 1);
    wait_idle();
    page(10'h1F0, 1);
    wait_idle();
    check("half count", 18'd9, 18'(got.size()));
    check("low half", {10'h1F0, 8'hA0}, got[8]);
    // Whole-array protection drops everything
    @(negedge clk) wp_n = 1'b1;
    frame(8'h06, 8'h00, 1);
    frame(8'h01, 8'h0C, 2);
    wait_idle();
    page(10'h000, 1);
    wait_idle();
    check("all count", 18'd9, 18'(got.size()));
    $display("protect test done");
    tally_and_finish();
  end
endmodule : spi_eeprom_status_and_framing_tb
`default_nettype wire
